/* logic/urt_irq_test.sv */
// UART interrupt clear, inert DMA control and integration test registers on APB
// Function
// - Clear bits 10, 9 drop overrun, break
// - Clear bits 8, 7 drop parity, framing
// - Clear bits 6, 5 drop timeout, transmit
// - DMA control ignores writes, reads zero
// - Test FIFO: write fills rx, read drains tx
// - Test FIFO off: data register works normally
// - Control bit 0 selects integration test mode
// - Test input bit 3 shows clear-to-send
// - Test input bit 0 shows receive pin
// - Test output bit 11 forces modem interrupt
// - Test output bits 10..8 force rx/tx/timeout
// - Test output bits 7, 6 force error/combined
// - Test output bits 3, 0 force rts/txd
// - Test data register moves 11-bit FIFO words
// - Raw status independent of mask, cleared
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module urt_irq_test
    import urt_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [IRQ_W-1:0] irqEvent,
    input wire logic normTxd,
    input wire logic normRtsN,
    input wire logic serialRxPin,
    input wire logic clearToSendN,
    input wire logic [WORD_W-1:0] rxFifoWord,
    input wire logic [WORD_W-1:0] txFifoWord,
    output logic rxFifoWrite,
    output logic txFifoWrite,
    output logic [WORD_W-1:0] fifoWriteWord,
    output logic rxFifoRead,
    output logic txFifoRead,
    output logic serialTxPin,
    output logic requestToSendN,
    output logic rxIrq,
    output logic txIrq,
    output logic rxTimeoutIrq,
    output logic errorIrq,
    output logic modemIrq,
    output logic combinedIrq
);

    // Map is decoded on the package's address width only
    if (ADDR_BITS != ADDR_W)
    begin : gBadAddr
        $error("urt_irq_test: ADDR_BITS must equal ADDR_W");
    end

    function automatic logic hit(input logic [ADDR_BITS-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Pin synchronisers
    logic rxdMeta_reg, rxdSync_reg, ctsMeta_reg, ctsSync_reg;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxdMeta_reg <= 1'h1;
            rxdSync_reg <= 1'h1;
            ctsMeta_reg <= 1'h1;
            ctsSync_reg <= 1'h1;
        end
        else
        begin
            rxdMeta_reg <= serialRxPin;
            rxdSync_reg <= rxdMeta_reg;
            ctsMeta_reg <= clearToSendN;
            ctsSync_reg <= ctsMeta_reg;
        end
    end

    logic [IRQ_W-1:0] raw_reg, raw_next, mask_reg, mask_next;
    logic [1:0] tctl_reg, tctl_next;
    logic [11:0] tout_reg, tout_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    logic rxWr_next, txWr_next, rxRd_next, txRd_next;
    logic [WORD_W-1:0] word_next;
    logic txd_next, rts_next, rxI_next, txI_next, rtI_next, errI_next, msI_next, allI_next;
    logic [IRQ_W-1:0] masked;
    logic setup, wrDone, rdDone, mapped, fifoTest, itEn;

    // Bus phases; one wait-free access cycle follows each setup
    assign setup = psel && !penable;
    assign wrDone = psel && penable && pready && pwrite;
    assign rdDone = psel && penable && pready && !pwrite;
    assign masked = raw_reg & mask_reg;
    assign fifoTest = tctl_reg[B_TFIFO];
    assign itEn = tctl_reg[B_ITEN];
    assign mapped = hit(paddr, OFF_DATA) || hit(paddr, OFF_MASK) || hit(paddr, OFF_RAW)
        || hit(paddr, OFF_MSKD) || hit(paddr, OFF_ICLR) || hit(paddr, OFF_DMA)
        || hit(paddr, OFF_TCTL) || hit(paddr, OFF_TIN) || hit(paddr, OFF_TOUT)
        || hit(paddr, OFF_TDAT);

    // Next state of registers, bus answer, FIFO strobes and output pins
    always_comb
    begin
        raw_next = raw_reg;
        mask_next = mask_reg;
        tctl_next = tctl_reg;
        tout_next = tout_reg;
        prdata_next = prdata;
        pready_next = setup;
        pslverr_next = setup && !mapped;
        rxWr_next = 1'h0;
        txWr_next = 1'h0;
        rxRd_next = 1'h0;
        txRd_next = 1'h0;
        word_next = fifoWriteWord;
        // Clear first, then set, so a same-cycle event is kept
        if (wrDone && hit(paddr, OFF_ICLR))
        begin
            raw_next = raw_next & ~(pwdata[IRQ_W-1:0] & IRQ_IMPL);
        end
        raw_next = raw_next | (irqEvent & IRQ_IMPL);
        // Register writes land only at the access edge with pready high
        if (wrDone)
        begin
            if (hit(paddr, OFF_MASK))
            begin
                mask_next = pwdata[IRQ_W-1:0] & IRQ_IMPL;
            end
            if (hit(paddr, OFF_TCTL))
            begin
                tctl_next = pwdata[1:0];
            end
            if (hit(paddr, OFF_TOUT))
            begin
                tout_next = pwdata[11:0] & TOUT_IMPL;
            end
            // Data register: test path into rx FIFO, else normal transmit
            if (hit(paddr, OFF_DATA))
            begin
                rxWr_next = fifoTest;
                txWr_next = !fifoTest;
                word_next = pwdata[WORD_W-1:0];
            end
            // Test data register only acts with the test path on
            if (hit(paddr, OFF_TDAT) && fifoTest)
            begin
                rxWr_next = 1'h1;
                word_next = pwdata[WORD_W-1:0];
            end
        end
        // Pop strobes follow the completed read, one per transfer
        if (rdDone)
        begin
            if (hit(paddr, OFF_DATA))
            begin
                txRd_next = fifoTest;
                rxRd_next = !fifoTest;
            end
            if (hit(paddr, OFF_TDAT) && fifoTest)
            begin
                txRd_next = 1'h1;
            end
        end
        // Read data is latched at setup so it stands for the access cycle
        if (setup && !pwrite)
        begin
            prdata_next = RST_WORD;
            // DMA control has no storage, so its read stays all zero
            if (hit(paddr, OFF_DMA))
            begin
                prdata_next = RST_WORD;
            end
            if (hit(paddr, OFF_DATA))
            begin
                prdata_next[WORD_W-1:0] = fifoTest ? txFifoWord : rxFifoWord;
            end
            if (hit(paddr, OFF_MASK))
            begin
                prdata_next[IRQ_W-1:0] = mask_reg;
            end
            if (hit(paddr, OFF_RAW))
            begin
                prdata_next[IRQ_W-1:0] = raw_reg;
            end
            if (hit(paddr, OFF_MSKD))
            begin
                prdata_next[IRQ_W-1:0] = masked;
            end
            if (hit(paddr, OFF_TCTL))
            begin
                prdata_next[1:0] = tctl_reg;
            end
            if (hit(paddr, OFF_TIN))
            begin
                prdata_next[B_CTSIN] = ctsSync_reg;
                prdata_next[B_RXDIN] = rxdSync_reg;
            end
            // Reads show the pins after the mux, not the stored values
            if (hit(paddr, OFF_TOUT))
            begin
                prdata_next[B_FMS] = modemIrq;
                prdata_next[B_FRX] = rxIrq;
                prdata_next[B_FTX] = txIrq;
                prdata_next[B_FRT] = rxTimeoutIrq;
                prdata_next[B_FERR] = errorIrq;
                prdata_next[B_FALL] = combinedIrq;
                prdata_next[B_FRTS] = requestToSendN;
                prdata_next[B_FTXD] = serialTxPin;
            end
            if (hit(paddr, OFF_TDAT) && fifoTest)
            begin
                prdata_next[WORD_W-1:0] = txFifoWord;
            end
        end
        // Output multiplexer: forced values only in integration test mode
        if (itEn)
        begin
            msI_next = tout_reg[B_FMS];
            rxI_next = tout_reg[B_FRX];
            txI_next = tout_reg[B_FTX];
            rtI_next = tout_reg[B_FRT];
            errI_next = tout_reg[B_FERR];
            allI_next = tout_reg[B_FALL];
            rts_next = tout_reg[B_FRTS];
            txd_next = tout_reg[B_FTXD];
        end
        else
        begin
            msI_next = masked[B_CTS];
            rxI_next = masked[B_RX];
            txI_next = masked[B_TX];
            rtI_next = masked[B_RTO];
            errI_next = masked[B_OVR] | masked[B_BRK] | masked[B_PAR] | masked[B_FRM];
            allI_next = |masked;
            rts_next = normRtsN;
            txd_next = normTxd;
        end
    end

    // All control and test fields reset to zero; idle pins reset high
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_reg <= '0;
            mask_reg <= '0;
            tctl_reg <= 2'h0;
            tout_reg <= 12'h000;
            prdata <= RST_WORD;
            pready <= 1'h0;
            pslverr <= 1'h0;
            rxFifoWrite <= 1'h0;
            txFifoWrite <= 1'h0;
            rxFifoRead <= 1'h0;
            txFifoRead <= 1'h0;
            fifoWriteWord <= '0;
            serialTxPin <= 1'h1;
            requestToSendN <= 1'h1;
            rxIrq <= 1'h0;
            txIrq <= 1'h0;
            rxTimeoutIrq <= 1'h0;
            errorIrq <= 1'h0;
            modemIrq <= 1'h0;
            combinedIrq <= 1'h0;
        end
        else
        begin
            raw_reg <= raw_next;
            mask_reg <= mask_next;
            tctl_reg <= tctl_next;
            tout_reg <= tout_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            rxFifoWrite <= rxWr_next;
            txFifoWrite <= txWr_next;
            rxFifoRead <= rxRd_next;
            txFifoRead <= txRd_next;
            fifoWriteWord <= word_next;
            serialTxPin <= txd_next;
            requestToSendN <= rts_next;
            rxIrq <= rxI_next;
            txIrq <= txI_next;
            rxTimeoutIrq <= rtI_next;
            errorIrq <= errI_next;
            modemIrq <= msI_next;
            combinedIrq <= allI_next;
        end
    end

    // Checks; outputs lag their cause by one register stage
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_clear_drops_raw: assert property (
        (wrDone && hit(paddr, OFF_ICLR) && irqEvent == '0)
        |=> ((raw_reg & $past(pwdata[IRQ_W-1:0]) & IRQ_IMPL) == '0))
        else $error("clear write left a raw bit set");
    chk_event_sets_raw: assert property (
        (irqEvent[B_OVR] && IRQ_IMPL[B_OVR]) |=> raw_reg[B_OVR] ##1 (raw_reg[B_OVR] || $past(wrDone)))
        else $error("overrun event lost");
    chk_dma_reads_zero: assert property (
        (setup && !pwrite && hit(paddr, OFF_DMA)) |=> (prdata == RST_WORD && pready))
        else $error("dma control read not zero");
    chk_test_push_rx: assert property (
        (wrDone && hit(paddr, OFF_DATA) && fifoTest) |=> (rxFifoWrite && !txFifoWrite))
        else $error("test write did not reach rx fifo");
    chk_normal_push_tx: assert property (
        (wrDone && hit(paddr, OFF_DATA) && !fifoTest) |=> (txFifoWrite && !rxFifoWrite))
        else $error("normal write reached rx fifo");
    chk_forced_pins: assert property (
        itEn |=> (serialTxPin == $past(tout_reg[B_FTXD]) && requestToSendN == $past(tout_reg[B_FRTS])))
        else $error("forced serial pins wrong");
    chk_forced_irqs: assert property (
        itEn |=> (rxIrq == $past(tout_reg[B_FRX]) && modemIrq == $past(tout_reg[B_FMS])
            && combinedIrq == $past(tout_reg[B_FALL])))
        else $error("forced interrupt wrong");
    chk_normal_irq: assert property (
        (!itEn && rst_n) |=> (combinedIrq == $past(|masked) && serialTxPin == $past(normTxd)))
        else $error("normal interrupt path wrong");
    chk_input_sample: assert property (
        (setup && !pwrite && hit(paddr, OFF_TIN))
        |=> (prdata[B_RXDIN] == $past(rxdSync_reg) && prdata[B_CTSIN] == $past(ctsSync_reg)))
        else $error("test input sample wrong");
    chk_unmapped_err: assert property (
        (setup && !mapped) |=> (pready && pslverr))
        else $error("unmapped access not refused");
    // FIFO path strobes and the word that travels with them
    chk_test_pop_tx: assert property (
        (rdDone && hit(paddr, OFF_DATA) && fifoTest) |=> (txFifoRead && !rxFifoRead))
        else $error("test read did not pop tx fifo");
    chk_tdat_word: assert property (
        (wrDone && hit(paddr, OFF_TDAT) && fifoTest)
        |=> (rxFifoWrite && fifoWriteWord == $past(pwdata[WORD_W-1:0])))
        else $error("test data word not pushed");
    chk_tdat_inert: assert property (
        (psel && penable && hit(paddr, OFF_TDAT) && !fifoTest)
        |=> !(rxFifoWrite || txFifoWrite || rxFifoRead || txFifoRead))
        else $error("test data register acted with path off");
    // Forced error and timeout lines, modem path, and the set that beats a clear
    chk_forced_err: assert property (
        itEn |=> (errorIrq == $past(tout_reg[B_FERR]) && txIrq == $past(tout_reg[B_FTX])
            && rxTimeoutIrq == $past(tout_reg[B_FRT])))
        else $error("forced error or timeout interrupt wrong");
    chk_set_beats_clear: assert property (
        (wrDone && hit(paddr, OFF_ICLR) && (irqEvent & IRQ_IMPL) != '0)
        |=> ((raw_reg & $past(irqEvent & IRQ_IMPL)) == $past(irqEvent & IRQ_IMPL)))
        else $error("event lost to a same-cycle clear");
    chk_modem_normal: assert property (
        (!itEn && rst_n) |=> (modemIrq == $past(masked[B_CTS]) && requestToSendN == $past(normRtsN)))
        else $error("normal modem or rts path wrong");

    // Main scenarios the bench is expected to reach
    cov_test_fifo_read: cover property (rdDone && hit(paddr, OFF_TDAT) && fifoTest);
    cov_clear_vs_event: cover property (wrDone && hit(paddr, OFF_ICLR) && (irqEvent & pwdata[IRQ_W-1:0]) != '0);
    cov_forced_irq: cover property (itEn && tout_reg[B_FALL] ##1 combinedIrq);
    cov_modem_normal: cover property (!itEn && masked[B_CTS] ##1 modemIrq);

endmodule // urt_irq_test

/* logic/urt_pkg.sv */
// Register map, field layout and widths of the UART interrupt-clear and test block
package urt_pkg;
    localparam int ADDR_W = 12;
    localparam int IRQ_W = 11;
    localparam int WORD_W = 11;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_DATA = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_MASK = 12'h038;
    localparam logic [ADDR_W-1:0] OFF_RAW = 12'h03c;
    localparam logic [ADDR_W-1:0] OFF_MSKD = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_ICLR = 12'h044;
    localparam logic [ADDR_W-1:0] OFF_DMA = 12'h048;
    localparam logic [ADDR_W-1:0] OFF_TCTL = 12'h080;
    localparam logic [ADDR_W-1:0] OFF_TIN = 12'h084;
    localparam logic [ADDR_W-1:0] OFF_TOUT = 12'h088;
    localparam logic [ADDR_W-1:0] OFF_TDAT = 12'h08c;
    // Interrupt source bit positions
    localparam int B_OVR = 10;
    localparam int B_BRK = 9;
    localparam int B_PAR = 8;
    localparam int B_FRM = 7;
    localparam int B_RTO = 6;
    localparam int B_TX = 5;
    localparam int B_RX = 4;
    localparam int B_CTS = 1;
    // Implemented interrupt bits; modem bits 3, 2, 0 are unsupported
    localparam logic [IRQ_W-1:0] IRQ_IMPL = 11'h7f2;
    // Test control fields
    localparam int B_TFIFO = 1;
    localparam int B_ITEN = 0;
    // Test input fields
    localparam int B_CTSIN = 3;
    localparam int B_RXDIN = 0;
    // Test output fields
    localparam int B_FMS = 11;
    localparam int B_FRX = 10;
    localparam int B_FTX = 9;
    localparam int B_FRT = 8;
    localparam int B_FERR = 7;
    localparam int B_FALL = 6;
    localparam int B_FRTS = 3;
    localparam int B_FTXD = 0;
    localparam logic [11:0] TOUT_IMPL = 12'hfc9;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

/* testbench/urt_irq_test_tb.sv */
// Self-checking bench for the UART interrupt clear and test registers
`timescale 1ns/1ps
module urt_irq_test_tb;
    import urt_pkg::*;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, normTxd, normRtsN, err;
    logic rxFifoWrite, txFifoWrite, rxFifoRead, txFifoRead, serialTxPin, requestToSendN;
    logic rxIrq, txIrq, rxTimeoutIrq, errorIrq, modemIrq, combinedIrq, serialRxPin, clearToSendN;
    logic rxLvl, ctsLvl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, tv;
    logic [15:0] lfsr;
    logic [IRQ_W-1:0] irqEvent;
    logic [WORD_W-1:0] rxFifoWord, txFifoWord, fifoWriteWord, lastWord;
    logic [31:0] pinWord;
    int bad_count, cmp_count, nRxW, nTxW, nRxR, nTxR, eRxW, eTxW, eRxR, eTxR;
    int srcs[8] = '{10, 9, 8, 7, 6, 5, 4, 1};

    urt_irq_test urt_irq_test_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqEvent(irqEvent), .normTxd(normTxd), .normRtsN(normRtsN),
        .serialRxPin(serialRxPin), .clearToSendN(clearToSendN), .rxFifoWord(rxFifoWord),
        .txFifoWord(txFifoWord), .rxFifoWrite(rxFifoWrite), .txFifoWrite(txFifoWrite),
        .fifoWriteWord(fifoWriteWord), .rxFifoRead(rxFifoRead), .txFifoRead(txFifoRead),
        .serialTxPin(serialTxPin), .requestToSendN(requestToSendN), .rxIrq(rxIrq), .txIrq(txIrq),
        .rxTimeoutIrq(rxTimeoutIrq), .errorIrq(errorIrq), .modemIrq(modemIrq), .combinedIrq(combinedIrq));
    urt_remote_dev urt_remote_dev_i (.ref_clk(ref_clk), .rxLevel(rxLvl), .ctsLevel(ctsLvl),
        .serialRxPin(serialRxPin), .clearToSendN(clearToSendN));

    // Output pins laid out like the test output register
    assign pinWord = {20'h0, modemIrq, rxIrq, txIrq, rxTimeoutIrq, errorIrq, combinedIrq, 2'b00,
        requestToSendN, 2'b00, serialTxPin};

    // Strobe counters, so a missing or doubled pulse shows up
    always @(posedge ref_clk)
    begin
        if (rxFifoWrite === 1'b1) nRxW++;
        if (txFifoWrite === 1'b1) nTxW++;
        if (rxFifoRead === 1'b1) nRxR++;
        if (txFifoRead === 1'b1) nTxR++;
        if ((rxFifoWrite | txFifoWrite) === 1'b1) lastWord <= fifoWriteWord;
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected normal-mode outputs {modem, err, tx, timeout, rx, combined} for one source
    function automatic logic [5:0] irq_exp(input int b);
        return {b == 1, b >= 7, b == 5, b == 6, b == 4, 1'b1};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen, bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic strobes();
        repeat (2) @(posedge ref_clk);
        check("strobes", {8'(nRxW), 8'(nTxW), 8'(nRxR), 8'(nTxR)}, {8'(eRxW), 8'(eTxW), 8'(eRxR), 8'(eTxR)});
    endtask

    initial
    begin
        {psel, penable, pwrite, rxLvl, ctsLvl, rst_n} = '0;
        {normTxd, normRtsN} = 2'b11;
        paddr = '0;
        pwdata = '0;
        irqEvent = '0;
        lfsr = 16'h0028;
        rxFifoWord = 11'h123;
        txFifoWord = 11'h456;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        // Reset state: normal mode, fifo path off
        apb(1'b0, OFF_TCTL, 32'h0);
        check("tctl_rst", rd, 32'h0);
        apb(1'b0, OFF_TOUT, 32'h0);
        check("tout_rst", rd, 32'h0000_0009);
        // Inert DMA control and an unmapped place
        apb(1'b1, OFF_DMA, 32'h0000_0007);
        apb(1'b0, OFF_DMA, 32'h0);
        check("dma", rd, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        // Each source sets raw and outputs, then its clear bit drops it
        apb(1'b1, OFF_MASK, 32'h0000_07f2);
        foreach (srcs[i])
        begin
            irqEvent <= 11'h001 << srcs[i];
            @(posedge ref_clk);
            irqEvent <= '0;
            repeat (3) @(posedge ref_clk);
            apb(1'b0, OFF_RAW, 32'h0);
            check("raw_set", rd, 32'h1 << srcs[i]);
            check("irq_out", {26'h0, modemIrq, errorIrq, txIrq, rxTimeoutIrq, rxIrq, combinedIrq},
                {26'h0, irq_exp(srcs[i])});
            apb(1'b1, OFF_ICLR, 32'h1 << srcs[i]);
            apb(1'b0, OFF_RAW, 32'h0);
            check("raw_clr", rd, 32'h0);
            check("irq_low", {31'h0, combinedIrq}, 32'h0);
        end
        // Masked source still records raw status
        apb(1'b1, OFF_MASK, 32'h0);
        irqEvent <= 11'h400;
        @(posedge ref_clk);
        irqEvent <= '0;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, OFF_RAW, 32'h0);
        check("raw_masked", rd, 32'h0000_0400);
        check("comb_masked", {31'h0, combinedIrq}, 32'h0);
        apb(1'b1, OFF_ICLR, 32'h0000_0400);
        // Clear and event at the same edge: the event wins
        fork
            apb(1'b1, OFF_ICLR, 32'h0000_0400);
            begin
                @(posedge ref_clk);
                irqEvent <= 11'h400;
                @(posedge ref_clk);
                irqEvent <= '0;
            end
        join
        apb(1'b0, OFF_RAW, 32'h0);
        check("set_wins", rd, 32'h0000_0400);
        apb(1'b1, OFF_ICLR, 32'h0000_0400);
        // Test inputs follow the receive and clear-to-send pins
        repeat (4)
        begin
            lfsr = lfsr_next(lfsr);
            rxLvl <= lfsr[0];
            ctsLvl <= lfsr[1];
            repeat (4) @(posedge ref_clk);
            apb(1'b0, OFF_TIN, 32'h0);
            check("test_in", rd, {28'h0, ctsLvl, 2'b00, rxLvl});
        end
        // Integration test mode forces outputs from the test output register
        apb(1'b1, OFF_TCTL, 32'h0000_0001);
        repeat (5)
        begin
            lfsr = lfsr_next(lfsr);
            tv = {20'h0, lfsr[11:0]} & 32'h0000_0fc9;
            apb(1'b1, OFF_TOUT, tv);
            repeat (2) @(posedge ref_clk);
            check("forced_pins", pinWord, tv);
            apb(1'b0, OFF_TOUT, 32'h0);
            check("tout_read", rd, tv);
        end
        apb(1'b1, OFF_TCTL, 32'h0);
        normTxd <= lfsr[2];
        normRtsN <= lfsr[3];
        repeat (3) @(posedge ref_clk);
        check("normal_pins", pinWord, {28'h0, normRtsN, 2'b00, normTxd});
        // Test fifo path on: data writes fill rx, reads drain tx
        apb(1'b1, OFF_TCTL, 32'h0000_0002);
        tv = {21'h0, lfsr[10:0]};
        apb(1'b1, OFF_DATA, tv);
        eRxW++;
        strobes();
        check("rx_word", {21'h0, lastWord}, tv);
        apb(1'b0, OFF_DATA, 32'h0);
        eTxR++;
        check("tx_read", rd, {21'h0, txFifoWord});
        apb(1'b1, OFF_TDAT, 32'h0000_07ff);
        eRxW++;
        apb(1'b0, OFF_TDAT, 32'h0);
        eTxR++;
        strobes();
        check("tdat", {21'h0, lastWord}, 32'h0000_07ff);
        // Test fifo path off: data register works normally, test data inert
        apb(1'b1, OFF_TCTL, 32'h0);
        apb(1'b1, OFF_DATA, 32'h0000_0055);
        eTxW++;
        apb(1'b0, OFF_DATA, 32'h0);
        eRxR++;
        check("rx_read", rd, {21'h0, rxFifoWord});
        apb(1'b1, OFF_TDAT, 32'h0000_0011);
        apb(1'b0, OFF_TDAT, 32'h0);
        check("tdat_off", rd, 32'h0);
        strobes();
        check("tx_word", {21'h0, lastWord}, 32'h0000_0055);
        // Reset in mid-run with both test bits set returns to normal operation
        apb(1'b1, OFF_TCTL, 32'h0000_0003);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, OFF_TCTL, 32'h0);
        check("tctl_rst2", rd, 32'h0);
        apb(1'b0, OFF_TOUT, 32'h0);
        check("tout_rst2", rd, {28'h0, normRtsN, 2'b00, normTxd});
        apb(1'b1, OFF_TCTL, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        check("tout_zero", pinWord, 32'h0);
        complete_run();
    end
endmodule // urt_irq_test_tb

/* testbench/urt_remote_dev.sv */
// Remote serial device model driving the receive line and clear-to-send pin
`timescale 1ns/1ps
module urt_remote_dev
(
    input wire logic ref_clk,
    input wire logic rxLevel,
    input wire logic ctsLevel,
    output logic serialRxPin,
    output logic clearToSendN
);
    // Idle line and deasserted flow control before the first edge
    initial
    begin
        serialRxPin = 1'b1;
        clearToSendN = 1'b1;
    end

    // Pins follow the requested levels one edge later; the design synchronises them
    always @(posedge ref_clk)
    begin
        serialRxPin <= rxLevel;
        clearToSendN <= ctsLevel;
    end
endmodule // urt_remote_dev
